// *** logic/pbm_pkg.sv ***
// port bus mode controller: shared constants, types and the address decode
package pbm_pkg;

  // ------------------------------------------------------------
  // constants
  // ------------------------------------------------------------
  localparam int PBM_PORT_W = 8;
  localparam int PBM_SYNC_W = 25;
  localparam int PBM_SY_STB = 24;
  localparam int PBM_SY_PB = 16;
  localparam int PBM_SY_PC = 8;
  localparam int PBM_SY_PD = 0;
  localparam int PBM_PC_A12 = 4;
  localparam int PBM_PC_RW = 5;
  localparam int PBM_PC_A13 = 6;
  localparam int PBM_PC_SEL = 7;
  localparam int PBM_PC_A14 = 7;
  localparam logic [15:0] PBM_EMS_LO = 16'h0100;
  localparam logic [15:0] PBM_EMS_HI = 16'h3fff;
  localparam logic [7:0] PBM_PORT_RST = 8'h00;
  localparam logic [7:0] PBM_ALL_ON = 8'hff;
  localparam logic [24:0] PBM_SYNC_RST = 25'h000_0000;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    PBM_FULL_ADDR = 2'h0,
    PBM_IO_BUS = 2'h1,
    PBM_MUX = 2'h3,
    PBM_ABBREV = 2'h2
  } pbm_bus_mode_t;

  typedef struct packed {
    logic bus_mode_high_bit;
    logic bus_mode_low_bit;
    logic tristate_select_bit;
    logic latch_enable_bit;
  } pbm_mode_t;

  typedef struct packed {
    logic valid;
    logic rw;
    logic [15:0] addr;
    logic [7:0] wdata;
  } pbm_cpu_t;

  typedef struct packed {
    logic [7:0] data;
    logic [7:0] dir;
  } pbm_port_t;

  function automatic logic pbm_ems_hit(input pbm_cpu_t c);
    return c.valid && (c.addr >= PBM_EMS_LO) && (c.addr <= PBM_EMS_HI);
  endfunction : pbm_ems_hit

endpackage : pbm_pkg

// *** logic/pbm_port_bus_ctrl.sv ***
// port bus mode controller: pin roles, driver enables, select and input latch
`timescale 1ns/1ps
`default_nettype none
module pbm_port_bus_ctrl (
  input wire logic clk_sys_in, // 10 MHz system clock
  input wire logic reset_n_in, // async reset, low
  input wire logic clk_en_in, // freezes all state when low
  input wire pbm_pkg::pbm_mode_t mode_control_reg_in, // mode bits 7..4
  input wire logic phase2_in, // processor phase 2, same clock
  input wire pbm_pkg::pbm_cpu_t cpu_bus_in, // processor access
  input wire pbm_pkg::pbm_port_t latch_port_drive_in, // port data and direction
  input wire pbm_pkg::pbm_port_t addr_port_drive_in, // port data and direction
  input wire pbm_pkg::pbm_port_t data_port_drive_in, // port data; direction ignored, tristate bit sets the enable
  input wire logic strobe_input_pin_in, // latch strobe pin
  input wire logic [7:0] latchable_port_pins_in, // pin levels
  output logic [7:0] latchable_port_pins_out, // pin drive value
  output logic [7:0] latchable_port_pins_oe_out, // pin drive enable
  input wire logic [7:0] address_port_pins_in, // pin levels
  output logic [7:0] address_port_pins_out, // pin drive value
  output logic [7:0] address_port_pins_oe_out, // pin drive enable
  input wire logic [7:0] data_port_pins_in, // pin levels
  output logic [7:0] data_port_pins_out, // pin drive value
  output logic [7:0] data_port_pins_oe_out, // pin drive enable
  output logic [7:0] latch_port_read_out, // latched or live port value
  output logic [7:0] address_port_read_out, // filtered pin value
  output logic [7:0] data_port_read_out, // filtered pin value
  output logic [7:0] cpu_rdata_out, // data bus read capture
  output logic ext_mem_select_n_out, // memory select, low
  output var pbm_pkg::pbm_bus_mode_t bus_mode_out // decoded bus mode
);
  import pbm_pkg::*;

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  // a change counts only once stages two and three agree
  logic [PBM_SYNC_W-1:0] sync_a;
  logic [PBM_SYNC_W-1:0] sync_b;
  logic [PBM_SYNC_W-1:0] sync_c;
  logic [PBM_SYNC_W-1:0] filt;
  logic [PBM_SYNC_W-1:0] next_sync_a;
  logic [PBM_SYNC_W-1:0] next_sync_b;
  logic [PBM_SYNC_W-1:0] next_sync_c;
  logic [PBM_SYNC_W-1:0] next_filt;

  always_comb begin
    next_sync_a = {strobe_input_pin_in, latchable_port_pins_in,
                   address_port_pins_in, data_port_pins_in};
    next_sync_b = sync_a;
    next_sync_c = sync_b;
    next_filt = filt;
    for (int i = 0; i < PBM_SYNC_W; i++) begin
      if (sync_b[i] == sync_c[i]) begin
        next_filt[i] = sync_c[i];
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sync_a <= PBM_SYNC_RST;
      sync_b <= PBM_SYNC_RST;
      sync_c <= PBM_SYNC_RST;
      filt <= PBM_SYNC_RST;
    end else if (clk_en_in) begin
      sync_a <= next_sync_a;
      sync_b <= next_sync_b;
      sync_c <= next_sync_c;
      filt <= next_filt;
    end
  end

  // ------------------------------------------------------------
  // latchable port input latch
  // ------------------------------------------------------------
  logic strobe_prev;
  logic [7:0] in_latch;
  logic next_strobe_prev;
  logic [7:0] next_in_latch;
  logic strobe_rise;

  assign strobe_rise = filt[PBM_SY_STB] && !strobe_prev;

  always_comb begin
    next_strobe_prev = filt[PBM_SY_STB];
    next_in_latch = in_latch;
    if (mode_control_reg_in.latch_enable_bit && strobe_rise) begin
      next_in_latch = filt[PBM_SY_PB +: PBM_PORT_W];
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      strobe_prev <= 1'b0;
      in_latch <= PBM_PORT_RST;
    end else if (clk_en_in) begin
      strobe_prev <= next_strobe_prev;
      in_latch <= next_in_latch;
    end
  end

  // ------------------------------------------------------------
  // pin roles per bus mode
  // ------------------------------------------------------------
  pbm_bus_mode_t mode;
  logic sel_hit;
  logic bus_write_ph2;
  logic [7:0] next_pb_out;
  logic [7:0] next_pb_oe;
  logic [7:0] next_pc_out;
  logic [7:0] next_pc_oe;
  logic [7:0] next_pd_out;
  logic [7:0] next_pd_oe;
  logic [7:0] next_rdata;
  logic next_sel_n;

  assign mode = pbm_bus_mode_t'({mode_control_reg_in.bus_mode_high_bit,
                                 mode_control_reg_in.bus_mode_low_bit});
  assign sel_hit = pbm_ems_hit(cpu_bus_in);
  assign bus_write_ph2 = cpu_bus_in.valid && !cpu_bus_in.rw && phase2_in;

  always_comb begin
    next_pb_out = latch_port_drive_in.data;
    next_pb_oe = latch_port_drive_in.dir;
    if (mode_control_reg_in.latch_enable_bit) begin
      next_pb_oe = PBM_PORT_RST;
    end
    next_pc_out = addr_port_drive_in.data;
    next_pc_oe = addr_port_drive_in.dir;
    next_pd_out = data_port_drive_in.data;
    next_pd_oe = mode_control_reg_in.tristate_select_bit ? PBM_ALL_ON : PBM_PORT_RST;
    next_sel_n = !sel_hit;
    next_rdata = cpu_rdata_out;
    case (mode)
      PBM_FULL_ADDR: begin
        next_pc_out[PBM_PC_A13] = cpu_bus_in.addr[13];
        next_pc_out[PBM_PC_A14] = cpu_bus_in.addr[14];
        next_pc_oe[PBM_PC_A13] = 1'b1;
        next_pc_oe[PBM_PC_A14] = 1'b1;
      end
      PBM_IO_BUS: begin
        // plain I/O; the outside decodes 8K from the processor's own bus
        next_pc_oe = addr_port_drive_in.dir;
      end
      PBM_ABBREV, PBM_MUX: begin
        // six address bits on these pins give 64 peripheral slots
        next_pc_out[3:0] = cpu_bus_in.addr[3:0];
        next_pc_out[PBM_PC_A12] = cpu_bus_in.addr[12];
        next_pc_out[PBM_PC_RW] = cpu_bus_in.rw;
        next_pc_out[PBM_PC_A13] = cpu_bus_in.addr[13];
        next_pc_out[PBM_PC_SEL] = !sel_hit;
        next_pc_oe = PBM_ALL_ON;
        next_pd_out = cpu_bus_in.wdata;
        // drivers need the tristate bit that software must set here
        next_pd_oe = (bus_write_ph2 && mode_control_reg_in.tristate_select_bit)
                     ? PBM_ALL_ON : PBM_PORT_RST;
        if (mode == PBM_MUX && !phase2_in) begin
          // address on the port from the same clock edge at which select falls
          next_pd_out = cpu_bus_in.addr[11:4];
          next_pd_oe = mode_control_reg_in.tristate_select_bit ? PBM_ALL_ON : PBM_PORT_RST;
        end
        if (cpu_bus_in.valid && cpu_bus_in.rw && phase2_in) begin
          next_rdata = filt[PBM_SY_PD +: PBM_PORT_W];
        end
      end
      default: begin
        next_pc_oe = addr_port_drive_in.dir;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      latchable_port_pins_out <= PBM_PORT_RST;
      latchable_port_pins_oe_out <= PBM_PORT_RST;
      address_port_pins_out <= PBM_PORT_RST;
      address_port_pins_oe_out <= PBM_PORT_RST;
      data_port_pins_out <= PBM_PORT_RST;
      data_port_pins_oe_out <= PBM_PORT_RST;
      cpu_rdata_out <= PBM_PORT_RST;
      ext_mem_select_n_out <= 1'b1;
      bus_mode_out <= PBM_FULL_ADDR;
    end else if (clk_en_in) begin
      latchable_port_pins_out <= next_pb_out;
      latchable_port_pins_oe_out <= next_pb_oe;
      address_port_pins_out <= next_pc_out;
      address_port_pins_oe_out <= next_pc_oe;
      data_port_pins_out <= next_pd_out;
      data_port_pins_oe_out <= next_pd_oe;
      cpu_rdata_out <= next_rdata;
      ext_mem_select_n_out <= next_sel_n;
      bus_mode_out <= mode;
    end
  end

  // ------------------------------------------------------------
  // read-back values
  // ------------------------------------------------------------
  // live reads lag the pins by the synchroniser depth
  assign latch_port_read_out = mode_control_reg_in.latch_enable_bit
                               ? in_latch : filt[PBM_SY_PB +: PBM_PORT_W];
  assign address_port_read_out = filt[PBM_SY_PC +: PBM_PORT_W];
  assign data_port_read_out = filt[PBM_SY_PD +: PBM_PORT_W];

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking dcb @(posedge clk_sys_in);
  endclocking
  default disable iff (!reset_n_in);

  sequence s_bus_mode;
    clk_en_in && mode_control_reg_in.bus_mode_high_bit;
  endsequence

  sequence s_mux_addr_phase;
    s_bus_mode ##0 mode_control_reg_in.bus_mode_low_bit && !phase2_in
      && mode_control_reg_in.tristate_select_bit;
  endsequence

  sequence s_abbrev_write;
    s_bus_mode ##0 !mode_control_reg_in.bus_mode_low_bit && bus_write_ph2
      && mode_control_reg_in.tristate_select_bit;
  endsequence

  sequence s_bus_read;
    s_bus_mode ##0 cpu_bus_in.valid && cpu_bus_in.rw && phase2_in;
  endsequence

  a_io_bit_drive: assert property (clk_en_in && !mode_control_reg_in.latch_enable_bit
    |=> latchable_port_pins_oe_out == $past(latch_port_drive_in.dir))
    else $error("latchable port enable does not follow direction");

  a_latch_inputs: assert property (clk_en_in && mode_control_reg_in.latch_enable_bit
    |=> latchable_port_pins_oe_out == PBM_PORT_RST)
    else $error("latchable port driven while latch enabled");

  a_latch_capture: assert property (clk_en_in && strobe_rise && mode_control_reg_in.latch_enable_bit
    |=> in_latch == $past(filt[PBM_SY_PB +: PBM_PORT_W]))
    else $error("input latch missed the strobe edge");

  a_full_addr_pins: assert property (clk_en_in && mode == PBM_FULL_ADDR
    |=> address_port_pins_out[7:6] == $past(cpu_bus_in.addr[14:13])
        && address_port_pins_oe_out[7:6] == 2'h3
        && address_port_pins_oe_out[5:0] == $past(addr_port_drive_in.dir[5:0]))
    else $error("full address pins wrong");

  a_io_bus_plain: assert property (clk_en_in && mode == PBM_IO_BUS
    |=> address_port_pins_oe_out == $past(addr_port_drive_in.dir)
        && address_port_pins_out == $past(addr_port_drive_in.data))
    else $error("io bus mode port not plain");

  a_abbrev_pins: assert property (s_bus_mode
    |=> address_port_pins_oe_out == PBM_ALL_ON
        && address_port_pins_out == {$past(!sel_hit), $past(cpu_bus_in.addr[13]),
           $past(cpu_bus_in.rw), $past(cpu_bus_in.addr[12]), $past(cpu_bus_in.addr[3:0])})
    else $error("bus mode address pins wrong");

  a_select_range: assert property (clk_en_in
    |=> ext_mem_select_n_out == !($past(cpu_bus_in.valid)
        && $past(cpu_bus_in.addr) >= 16'h0100 && $past(cpu_bus_in.addr) <= 16'h3fff))
    else $error("memory select wrong for address");

  a_tristate_normal: assert property (clk_en_in && !mode_control_reg_in.bus_mode_high_bit
    |=> data_port_pins_oe_out == ($past(mode_control_reg_in.tristate_select_bit) ? 8'hff : 8'h00))
    else $error("data port enable ignores tristate bit");

  a_abbrev_data: assert property (s_abbrev_write
    |=> data_port_pins_oe_out == PBM_ALL_ON && data_port_pins_out == $past(cpu_bus_in.wdata))
    else $error("abbreviated write data not driven");

  a_mux_address: assert property (s_mux_addr_phase
    |=> data_port_pins_out == $past(cpu_bus_in.addr[11:4]) && data_port_pins_oe_out == PBM_ALL_ON)
    else $error("multiplexed address not on data port");

  a_data_quiet: assert property (s_bus_mode ##0 phase2_in && !bus_write_ph2
    |=> data_port_pins_oe_out == PBM_PORT_RST)
    else $error("data drivers on outside a write");

  // abbreviated mode keeps the data port off the pins until phase 2 of a write
  a_abbrev_idle: assert property (s_bus_mode ##0 !mode_control_reg_in.bus_mode_low_bit && !phase2_in
    |=> data_port_pins_oe_out == PBM_PORT_RST)
    else $error("abbreviated data drivers on in phase one");

  a_mux_data: assert property (s_bus_mode ##0 mode_control_reg_in.bus_mode_low_bit && bus_write_ph2
    && mode_control_reg_in.tristate_select_bit
    |=> data_port_pins_out == $past(cpu_bus_in.wdata) && data_port_pins_oe_out == PBM_ALL_ON)
    else $error("multiplexed write data not driven");

  // read data lags the pins by the synchroniser, so the filtered value is the reference
  a_read_capture: assert property (s_bus_read
    |=> cpu_rdata_out == $past(filt[PBM_SY_PD +: PBM_PORT_W]))
    else $error("read data not captured in phase two");

  a_latch_hold: assert property (clk_en_in && !(strobe_rise && mode_control_reg_in.latch_enable_bit)
    |=> in_latch == $past(in_latch))
    else $error("input latch changed without a strobe");

  a_bus_mode_out: assert property (clk_en_in
    |=> 2'(bus_mode_out) == $past({mode_control_reg_in.bus_mode_high_bit, mode_control_reg_in.bus_mode_low_bit}))
    else $error("reported bus mode wrong");

endmodule : pbm_port_bus_ctrl
`default_nettype wire

// *** verif/pbm_ext_mem_model.sv ***
// external memory and peripheral model on the expansion bus
`timescale 1ns/1ps
`default_nettype none
module pbm_ext_mem_model (
  input wire logic clk_sys_in, // system clock
  input wire logic [7:0] addr_pins_in, // address port pin levels
  input wire logic [7:0] dport_out_in, // data port drive value from device
  input wire logic [7:0] dport_oe_in, // data port drive enable from device
  input wire logic [7:0] read_byte_in, // byte returned on reads
  input wire logic [2:0] lag_in, // cycles before read data appears
  output logic [7:0] dport_level_out, // resolved data port level
  output logic [7:0] held_addr_out // address bits caught at select edge
);
  logic [7:0] drive;
  logic [2:0] wait_cnt;
  logic prev_sel_n;
  initial begin
    drive = 8'h00;
    wait_cnt = 3'h0;
    prev_sel_n = 1'b1;
    held_addr_out = 8'h00;
  end
  always @(posedge clk_sys_in) begin
    // leading edge of select strobes the multiplexed address into the holding register
    if (prev_sel_n && !addr_pins_in[7]) begin
      held_addr_out <= dport_level_out;
    end
    prev_sel_n <= addr_pins_in[7];
    if (!addr_pins_in[7] && addr_pins_in[5]) begin
      wait_cnt <= (wait_cnt == 3'h7) ? wait_cnt : wait_cnt + 3'h1;
      // released bus never keeps the last value, so an unread bus cannot match by chance
      drive <= (wait_cnt >= lag_in) ? read_byte_in : ~drive;
    end else begin
      wait_cnt <= 3'h0;
      drive <= ~drive;
    end
  end
  assign dport_level_out = (dport_oe_in & dport_out_in) | (~dport_oe_in & drive);
endmodule : pbm_ext_mem_model
`default_nettype wire

// *** verif/port_bus_mode_controller_tb.sv ***
// self-checking bench for the port bus mode controller
`timescale 1ns/1ps
`default_nettype none
module port_bus_mode_controller_tb;
  import pbm_pkg::*;
  logic clk_sys_in = 1'b0, reset_n_in = 1'b0, clk_en_in = 1'b1, phase2_in = 1'b0, strobe_in = 1'b0;
  pbm_mode_t mode = '0;
  pbm_cpu_t cpu = '0;
  pbm_port_t lp_drv = '0, ap_drv = '0, dp_drv = '0;
  logic [7:0] lp_pins = 8'h00, ap_pins = 8'h00, lp_out, lp_oe, ap_out, ap_oe, dp_out, dp_oe, dp_lvl;
  logic [7:0] lp_rd, ap_rd, dp_rd, rdata, held, rbyte = 8'hc3;
  logic sel_n;
  pbm_bus_mode_t bmode;
  int fail_count = 0, n_compared = 0;
  always #50 clk_sys_in = ~clk_sys_in;
  pbm_port_bus_ctrl uut (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .clk_en_in(clk_en_in),
    .mode_control_reg_in(mode), .phase2_in(phase2_in), .cpu_bus_in(cpu), .latch_port_drive_in(lp_drv),
    .addr_port_drive_in(ap_drv), .data_port_drive_in(dp_drv), .strobe_input_pin_in(strobe_in),
    .latchable_port_pins_in(lp_pins), .latchable_port_pins_out(lp_out), .latchable_port_pins_oe_out(lp_oe),
    .address_port_pins_in(ap_pins), .address_port_pins_out(ap_out), .address_port_pins_oe_out(ap_oe),
    .data_port_pins_in(dp_lvl), .data_port_pins_out(dp_out), .data_port_pins_oe_out(dp_oe),
    .latch_port_read_out(lp_rd), .address_port_read_out(ap_rd), .data_port_read_out(dp_rd),
    .cpu_rdata_out(rdata), .ext_mem_select_n_out(sel_n), .bus_mode_out(bmode));
  pbm_ext_mem_model partner (.clk_sys_in(clk_sys_in), .addr_pins_in(ap_out), .dport_out_in(dp_out),
    .dport_oe_in(dp_oe), .read_byte_in(rbyte), .lag_in(3'h2), .dport_level_out(dp_lvl), .held_addr_out(held));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk
  // inputs change on the falling edge; outputs are judged n rising edges later
  task automatic step(input pbm_mode_t m, input logic p2, input pbm_cpu_t c, input int n);
    mode = m;
    phase2_in = p2;
    cpu = c;
    repeat (n) @(negedge clk_sys_in);
  endtask : step
  task automatic test_done;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_plain_latch_port;
    lp_drv = '{data: 8'h3c, dir: 8'ha5};
    lp_pins = 8'h96;
    ap_pins = 8'h69;
    step('0, 1'b0, '0, 6);
    chk("address port read", 8'h69, ap_rd);
    chk("latch port oe", 8'ha5, lp_oe);
    chk("latch port out", 8'h24, lp_out & lp_oe);
    chk("latch port live read", 8'h96, lp_rd);
  endtask : t_plain_latch_port
  task automatic t_strobe_latch;
    step('{1'b0, 1'b0, 1'b0, 1'b1}, 1'b0, '0, 2);
    chk("latch port oe latched", 8'h00, lp_oe);
    lp_pins = 8'h5a;
    step(mode, 1'b0, '0, 4);
    strobe_in = 1'b1;
    step(mode, 1'b0, '0, 4);
    strobe_in = 1'b0;
    lp_pins = 8'h11;
    step(mode, 1'b0, '0, 8);
    chk("latched value", 8'h5a, lp_rd);
  endtask : t_strobe_latch
  task automatic t_full_and_io;
    ap_drv = '{data: 8'h15, dir: 8'h0f};
    step('{1'b0, 1'b0, 1'b0, 1'b0}, 1'b0, '{1'b1, 1'b1, 16'h6000, 8'h00}, 2);
    chk("full mode bus", 8'(PBM_FULL_ADDR), 8'(bmode));
    chk("full mode addr out", 8'hd5, ap_out);
    chk("full mode addr oe", 8'hcf, ap_oe);
    step('{1'b0, 1'b1, 1'b0, 1'b0}, 1'b0, cpu, 2);
    chk("io mode bus", 8'(PBM_IO_BUS), 8'(bmode));
    chk("io mode addr out", 8'h05, ap_out & ap_oe);
    chk("io mode addr oe", 8'h0f, ap_oe);
    chk("io mode data oe off", 8'h00, dp_oe);
    step('{1'b0, 1'b1, 1'b1, 1'b0}, 1'b0, cpu, 2);
    chk("io mode data oe on", 8'hff, dp_oe);
    step(mode, 1'b0, '{1'b1, 1'b1, 16'h9fff, 8'h00}, 2);
    chk("io mode ignores address", 8'h15, ap_out);
    chk("io mode select high", 8'h01, {7'h00, sel_n});
    // clock enable low must freeze the pins although the mode changes
    clk_en_in = 1'b0;
    step('{1'b0, 1'b0, 1'b0, 1'b0}, 1'b0, cpu, 2);
    chk("frozen bus mode", 8'(PBM_IO_BUS), 8'(bmode));
    chk("frozen addr oe", 8'h0f, ap_oe);
    clk_en_in = 1'b1;
    step(mode, 1'b0, cpu, 1);
    chk("resumed addr oe", 8'hcf, ap_oe);
  endtask : t_full_and_io
  task automatic t_abbrev;
    logic [15:0] a;
    logic [15:0] probe [4] = '{16'h00ff, 16'h0100, 16'h3fff, 16'h4000};
    step('{1'b1, 1'b0, 1'b1, 1'b0}, 1'b0, '{1'b1, 1'b0, 16'h1234, 8'h5a}, 2);
    chk("abbrev bus", 8'(PBM_ABBREV), 8'(bmode));
    chk("abbrev addr pins", 8'h14, ap_out);
    chk("abbrev addr oe", 8'hff, ap_oe);
    chk("abbrev write phase1 oe", 8'h00, dp_oe);
    step(mode, 1'b1, cpu, 2);
    chk("abbrev write data", 8'h5a, dp_out);
    chk("abbrev write oe", 8'hff, dp_oe);
    for (int i = 0; i < 64; i++) begin
      a = 16'h0100 | 16'(i[3:0]) | (16'(i[4]) << 12) | (16'(i[5]) << 13);
      step(mode, 1'b0, '{1'b1, 1'b1, a, 8'h00}, 1);
      chk("peripheral address", {1'b0, i[5], 1'b1, i[4], i[3:0]}, ap_out);
    end
    foreach (probe[k]) begin
      step(mode, 1'b0, '{1'b1, 1'b1, probe[k], 8'h00}, 1);
      chk("select", {7'h00, (k == 0 || k == 3)}, {7'h00, sel_n});
    end
    // partner answers after its lag, then three sync stages, the filter register and the capture edge
    step(mode, 1'b1, '{1'b1, 1'b1, 16'h0200, 8'h00}, 10);
    chk("abbrev read oe", 8'h00, dp_oe);
    chk("abbrev read data", rbyte, rdata);
    chk("data port read", rbyte, dp_rd);
  endtask : t_abbrev
  task automatic t_mux;
    step('{1'b1, 1'b1, 1'b1, 1'b0}, 1'b0, '0, 2);
    step(mode, 1'b0, '{1'b1, 1'b0, 16'h1234, 8'h5a}, 2);
    chk("mux bus", 8'(PBM_MUX), 8'(bmode));
    chk("mux address phase", 8'h23, dp_out);
    chk("mux address oe", 8'hff, dp_oe);
    chk("held address", 8'h23, held);
    step(mode, 1'b1, cpu, 1);
    chk("mux write data", 8'h5a, dp_out);
    step(mode, 1'b1, '{1'b1, 1'b1, 16'h1234, 8'h00}, 1);
    chk("mux read oe", 8'h00, dp_oe);
  endtask : t_mux
  // ------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    repeat (8) @(negedge clk_sys_in);
    reset_n_in = 1'b1;
    @(negedge clk_sys_in);
    t_plain_latch_port();
    t_strobe_latch();
    t_full_and_io();
    t_abbrev();
    t_mux();
    test_done();
  end
  // tests need about 130 cycles; allow about fifteen times that
  initial begin
    #200000;
    fail_count++;
    test_done();
  end
endmodule : port_bus_mode_controller_tb
`default_nettype wire
